// [verilog/adc_seq_pkg.sv]
/*
  Constants, register map and types for the conversion sequencer.
  Assumes a 20 MHz pclk and a 32-bit APB register bus.
*/
package adc_seq_pkg;

  // Clocking and timing
  localparam int PCLK_PERIOD_NS = 50;
  localparam int TICK_DIV       = 15;
  localparam int TICK_NS        = TICK_DIV * PCLK_PERIOD_NS;
  localparam int SYNC_NS        = 30000;
  localparam int DLY_STEP_NS    = 40000;
  localparam int CAL_NS         = 100000;
  // Longest times round down, least times round up
  localparam int SYNC_TICKS     = SYNC_NS / TICK_NS;
  localparam int DLY_STEP_TICKS = (DLY_STEP_NS + TICK_NS - 1) / TICK_NS;
  localparam int CAL_TICKS      = (CAL_NS + TICK_NS - 1) / TICK_NS;

  // Widths
  localparam int CODE_W   = 10;
  localparam int CHAN_W   = 4;
  localparam int SLOTS    = 8;
  localparam int SLOT_W   = 3;
  localparam int DLY_W    = 4;
  localparam int CNT_W    = 10;
  localparam int ADDR_W   = 12;
  localparam int RES_REGS = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 12'h000;
  localparam logic [ADDR_W-1:0] CHSEL_OFS   = 12'h004;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 12'h008;
  localparam logic [ADDR_W-1:0] MASK_OFS    = 12'h00c;
  localparam logic [ADDR_W-1:0] RESULT0_OFS = 12'h010;
  localparam logic [ADDR_W-1:0] RESULT1_OFS = 12'h014;
  localparam logic [ADDR_W-1:0] RESULT2_OFS = 12'h018;
  localparam logic [ADDR_W-1:0] RESULT3_OFS = 12'h01c;

  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_START_BIT  = 1;
  localparam int CTRL_CONT_BIT   = 2;
  localparam int CTRL_HOLD_BIT   = 3;
  localparam int CTRL_STOP_LSB   = 4;
  localparam int CTRL_FIRST_LSB  = 8;
  localparam int CTRL_INTER_LSB  = 12;
  localparam int CTRL_POST_LSB   = 16;

  // Status and mask fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_CAL_BIT  = 2;
  localparam int MASK_DONE_BIT = 0;

  // Result packing: even slot low, odd slot high
  localparam int RES_HI_LSB = 16;

  // Channel whose code is bipolar
  localparam logic [CHAN_W-1:0] BATT_CURRENT_CH = 4'h1;

  typedef struct packed {
    logic [DLY_W-1:0]  post_seq_delay;
    logic [DLY_W-1:0]  inter_conv_delay;
    logic [DLY_W-1:0]  first_conv_delay;
    logic [SLOT_W-1:0] seq_stop_slot;
    logic              result_hold;
    logic              conv_continuous;
    logic              conv_enable;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = '0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SYNC = 3'b001,
    ST_FDLY = 3'b011,
    ST_CONV = 3'b010,
    ST_GAP  = 3'b110,
    ST_POST = 3'b111,
    ST_CAL  = 3'b100
  } seq_state_type;

endpackage : adc_seq_pkg

// [verilog/adc_conversion_sequencer.sv]
/*
  Conversion sequencer for a 10-bit sixteen-channel converter, with APB registers.
  Assumes an analog core that converts on core_start and raises core_done
  asynchronously with core_code held stable until the next start.
*/
// Register access over APB and the register addresses are this design's own decisions.
// Notes on behaviour
// - Every conversion yields a 10-bit result code.
// - Sequencing runs from an internal 1.33 MHz tick, not the bus clock.
// - Sixteen channels, chosen by a four-bit channel number.
// - Over-range input gives the core full-scale code, passed on unaltered except the sign-bit flip on the battery current channel.
// - Sequence completion sets the done flag.
// - Mask bit keeps the done flag off the interrupt output.
// - Calibration runs after every power-up.
// - Enable low keeps the core powered down outside calibration, no conversions.
// - Start bit begins a sequence only while enabled.
// - First conversion waits sync time plus the first delay.
// - Inter-conversion delay sits between consecutive conversions.
// - Post-sequence delay applies only when looping continuously.
// - All delay fields reset to zero.
// - Delay equals code times 40 microseconds.
// - At most eight conversions per sequence.
// - Each slot converts its selected channel into its own result.
// - Sequence runs slot 0 through the stop slot inclusive.
// - Continuous bit loops the sequence repeatedly.
// - Continuous bit resets low.
// - Hold in continuous mode freezes the result registers.
// - Results appear in four result registers at sequence end.
// - Battery current code is two's complement.
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  // APB
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Analog core
  output logic                   core_power_en,
  output logic                   core_cal,
  output logic                   core_start,
  output logic      [CHAN_W-1:0] core_channel,
  input  wire logic              core_done,
  input  wire logic [CODE_W-1:0] core_code,
  // Interrupt
  output logic                   irq
);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  function automatic logic [CNT_W-1:0] dly_ticks(input logic [DLY_W-1:0] code);
    dly_ticks = CNT_W'(code * DLY_STEP_TICKS);
  endfunction : dly_ticks

  ctrl_type                  ctrl;
  logic [SLOTS*CHAN_W-1:0]   chsel;
  logic                      seq_done_flag;
  logic                      seq_done_mask;
  logic                      start_pending;
  seq_state_type             state;
  seq_state_type             next_state;
  logic [CNT_W-1:0]          cnt;
  logic [CNT_W-1:0]          next_cnt;
  logic [SLOT_W-1:0]         slot;
  logic [SLOT_W-1:0]         next_slot;
  localparam int TICK_CNT_W = $clog2(TICK_DIV);
  logic [TICK_CNT_W-1:0]     tick_cnt;
  logic                      tick;
  logic                      done_meta;
  logic                      done_sync;
  logic                      done_prev;
  logic [CODE_W-1:0]         code_meta;
  logic [CODE_W-1:0]         code_sync;
  logic                      conv_go;
  logic                      seq_end;
  logic                      accept;
  logic                      relatch;
  logic [CHAN_W-1:0]         shadow_sel [SLOTS];
  logic [SLOT_W-1:0]         shadow_stop;
  logic [DLY_W-1:0]          shadow_first;
  logic [DLY_W-1:0]          shadow_inter;
  logic [DLY_W-1:0]          shadow_post;
  logic [CODE_W-1:0]         work [SLOTS];
  logic [CODE_W-1:0]         result [SLOTS];
  logic [CODE_W-1:0]         merged [SLOTS];
  logic [CODE_W-1:0]         code_fixed;
  logic [31:0]               next_prdata;

  // Bus decode
  wire wr_en     = psel & penable & pwrite;
  wire rd_setup  = psel & ~penable & ~pwrite;
  wire addr_ok   = (paddr[ADDR_W-1:5] == '0) && (paddr[1:0] == 2'b00);
  wire wr_ctrl   = wr_en & reg_hit(paddr, CTRL_OFS);
  wire wr_chsel  = wr_en & reg_hit(paddr, CHSEL_OFS);
  wire wr_status = wr_en & reg_hit(paddr, STATUS_OFS);
  wire wr_mask   = wr_en & reg_hit(paddr, MASK_OFS);
  wire start_wr  = wr_ctrl & pwdata[CTRL_START_BIT] & pwdata[CTRL_ENABLE_BIT];
  wire done_edge = done_sync & ~done_prev;
  wire busy      = (state != ST_IDLE) && (state != ST_CAL);
  wire freeze    = ctrl.conv_continuous & ctrl.result_hold;

  // Zero-wait slave; pslverr only in the access phase of an unmapped address
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign irq     = seq_done_flag & ~seq_done_mask;

  // Internal converter rate, one pulse every TICK_DIV bus clocks
  assign tick = (tick_cnt == TICK_CNT_W'(TICK_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
    end
  end

  // Core outputs are asynchronous to pclk; first stages feed only the second
  // The code is stable from core_done onwards, so it is settled when the edge is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
      code_meta <= '0;
      code_sync <= '0;
    end else begin
      done_meta <= core_done;
      done_sync <= done_meta;
      done_prev <= done_sync;
      code_meta <= core_code;
      code_sync <= code_meta;
    end
  end

  // Host-visible configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl          <= CTRL_RESET;
      chsel         <= '0;
      seq_done_mask <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl.conv_enable      <= pwdata[CTRL_ENABLE_BIT];
        ctrl.conv_continuous  <= pwdata[CTRL_CONT_BIT];
        ctrl.result_hold      <= pwdata[CTRL_HOLD_BIT];
        ctrl.seq_stop_slot    <= pwdata[CTRL_STOP_LSB +: SLOT_W];
        ctrl.first_conv_delay <= pwdata[CTRL_FIRST_LSB +: DLY_W];
        ctrl.inter_conv_delay <= pwdata[CTRL_INTER_LSB +: DLY_W];
        ctrl.post_seq_delay   <= pwdata[CTRL_POST_LSB +: DLY_W];
      end
      if (wr_chsel) begin
        chsel <= pwdata[SLOTS*CHAN_W-1:0];
      end
      if (wr_mask) begin
        seq_done_mask <= pwdata[MASK_DONE_BIT];
      end
    end
  end

  // Start request; a new write in the accepting cycle stays pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pending <= 1'b0;
    end else if (start_wr) begin
      start_pending <= 1'b1;
    end else if (accept || !ctrl.conv_enable) begin
      start_pending <= 1'b0;
    end
  end

  // Done flag, write one to clear; a completing sequence beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_done_flag <= 1'b0;
    end else if (seq_end) begin
      seq_done_flag <= 1'b1;
    end else if (wr_status && pwdata[STAT_DONE_BIT]) begin
      seq_done_flag <= 1'b0;
    end
  end

  // Sequencer
  assign accept  = (state == ST_IDLE) && start_pending && ctrl.conv_enable;
  assign relatch = accept || (seq_end && ctrl.conv_continuous && ctrl.conv_enable);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_slot  = slot;
    conv_go    = 1'b0;
    seq_end    = 1'b0;
    case (state)
      ST_CAL: begin
        if (tick) begin
          if (cnt == '0) begin
            next_state = ST_IDLE;
          end else begin
            next_cnt = cnt - 1'b1;
          end
        end
      end
      ST_IDLE: begin
        if (start_pending) begin
          next_state = ST_SYNC;
          next_cnt   = CNT_W'(SYNC_TICKS - 1); // Exit on the last tick keeps sync within its bound
          next_slot  = '0;
        end
      end
      ST_SYNC: begin
        if (tick) begin
          if (cnt == '0) begin
            next_state = ST_FDLY;
            next_cnt   = dly_ticks(shadow_first);
          end else begin
            next_cnt = cnt - 1'b1;
          end
        end
      end
      ST_FDLY, ST_GAP, ST_POST: begin
        if (tick) begin
          if (cnt == '0) begin
            next_state = ST_CONV;
            conv_go    = 1'b1;
          end else begin
            next_cnt = cnt - 1'b1;
          end
        end
      end
      ST_CONV: begin
        if (done_edge) begin
          if (slot == shadow_stop) begin
            seq_end   = 1'b1;
            next_slot = '0;
            if (ctrl.conv_continuous) begin
              next_state = ST_POST;
              next_cnt   = dly_ticks(shadow_post);
            end else begin
              next_state = ST_IDLE;
            end
          end else begin
            next_state = ST_GAP;
            next_slot  = slot + 1'b1;
            next_cnt   = dly_ticks(shadow_inter);
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!ctrl.conv_enable && state != ST_CAL) begin
      next_state = ST_IDLE;
      conv_go    = 1'b0;
      seq_end    = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_CAL;
      cnt   <= CNT_W'(CAL_TICKS);
      slot  <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      slot  <= next_slot;
    end
  end

  // Core control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_start    <= 1'b0;
      core_channel  <= '0;
      core_power_en <= 1'b0;
      core_cal      <= 1'b0;
    end else begin
      core_start    <= conv_go;
      core_power_en <= ctrl.conv_enable | (next_state == ST_CAL);
      core_cal      <= (next_state == ST_CAL);
      if (conv_go) begin
        core_channel <= shadow_sel[next_slot];
      end
    end
  end

  // Bipolar channel arrives offset binary from the core; flip the sign bit
  // Over-range codes are whatever the calibrated core reports, not forced to max
  assign code_fixed = (core_channel == BATT_CURRENT_CH) ? {~code_sync[CODE_W-1], code_sync[CODE_W-2:0]}
                                                        : code_sync;

  genvar gi;
  generate
    for (gi = 0; gi < SLOTS; gi++) begin : g_slot
      assign merged[gi] = (SLOT_W'(gi) == slot) ? code_fixed : work[gi];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          shadow_sel[gi] <= '0;
          work[gi]       <= '0;
          result[gi]     <= '0;
        end else begin
          if (relatch) begin
            shadow_sel[gi] <= chsel[gi*CHAN_W +: CHAN_W];
          end
          if (state == ST_CONV && done_edge && SLOT_W'(gi) == slot) begin
            work[gi] <= code_fixed;
          end
          if (seq_end && !freeze) begin
            result[gi] <= merged[gi];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_stop  <= '0;
      shadow_first <= '0;
      shadow_inter <= '0;
      shadow_post  <= '0;
    end else if (relatch) begin
      shadow_stop  <= ctrl.seq_stop_slot;
      shadow_first <= ctrl.first_conv_delay;
      shadow_inter <= ctrl.inter_conv_delay;
      shadow_post  <= ctrl.post_seq_delay;
    end
  end

  // Read data, captured in the setup phase
  wire [31:0] rd_ctrl   = {12'h000, ctrl.post_seq_delay, ctrl.inter_conv_delay, ctrl.first_conv_delay, 1'b0,
                           ctrl.seq_stop_slot, ctrl.result_hold, ctrl.conv_continuous, start_pending,
                           ctrl.conv_enable};
  wire [31:0] rd_status = {29'h0, state == ST_CAL, busy, seq_done_flag};
  wire [1:0]  res_idx   = paddr[3:2];
  wire [31:0] rd_result = {6'h00, result[{res_idx, 1'b1}], 6'h00, result[{res_idx, 1'b0}]};

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (reg_hit(paddr, CTRL_OFS)) begin
      next_prdata = rd_ctrl;
    end else if (reg_hit(paddr, CHSEL_OFS)) begin
      next_prdata = chsel;
    end else if (reg_hit(paddr, STATUS_OFS)) begin
      next_prdata = rd_status;
    end else if (reg_hit(paddr, MASK_OFS)) begin
      next_prdata = {31'h0, seq_done_mask};
    end else if (addr_ok && paddr[4]) begin
      next_prdata = rd_result;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_accept;
    accept;
  endsequence

  sequence s_sync_hold;
    (state == ST_SYNC) [*8];
  endsequence

  property p_start_needs_enable;
    core_start |-> $past(ctrl.conv_enable);
  endproperty
  a_start_needs_enable: assert property (p_start_needs_enable) else $error("start issued while disabled");

  property p_done_sets_flag;
    seq_end |=> seq_done_flag;
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag) else $error("done flag not set");

  property p_mask_blocks_irq;
    seq_done_mask |-> !irq;
  endproperty
  a_mask_blocks_irq: assert property (p_mask_blocks_irq) else $error("masked flag reached irq");

  property p_start_self_clears;
    (accept && !start_wr) |=> !start_pending;
  endproperty
  a_start_self_clears: assert property (p_start_self_clears) else $error("start bit did not clear");

  property p_sync_first;
    s_accept |-> ##1 s_sync_hold;
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("sync phase skipped");

  property p_sync_bounded;
    $rose(state == ST_SYNC) |-> ##[1:600] (state != ST_SYNC);
  endproperty
  a_sync_bounded: assert property (p_sync_bounded) else $error("sync longer than allowed");

  property p_first_delay_load;
    (state == ST_SYNC && tick && cnt == '0 && ctrl.conv_enable) |=> (cnt == dly_ticks(shadow_first));
  endproperty
  a_first_delay_load: assert property (p_first_delay_load) else $error("wrong first delay");

  property p_slot_in_range;
    (state == ST_CONV) |-> (slot <= shadow_stop);
  endproperty
  a_slot_in_range: assert property (p_slot_in_range) else $error("slot past stop");

  property p_gap_after_conv;
    (state == ST_CONV && done_edge && slot != shadow_stop && ctrl.conv_enable) |=> (state == ST_GAP);
  endproperty
  a_gap_after_conv: assert property (p_gap_after_conv) else $error("inter delay skipped");

  property p_single_ends_idle;
    (seq_end && !ctrl.conv_continuous) |=> (state == ST_IDLE);
  endproperty
  a_single_ends_idle: assert property (p_single_ends_idle) else $error("single sequence looped");

  property p_hold_freezes;
    (seq_end && freeze) |=> (result[0] == $past(result[0]) && result[7] == $past(result[7]));
  endproperty
  a_hold_freezes: assert property (p_hold_freezes) else $error("results changed under hold");

endmodule : adc_conversion_sequencer

// [verif/adc_core_model.sv]
/*
  Behavioural model of the analog converter core behind the sequencer.
  Assumes one-pclk core_start pulses and answers each after a fixed latency.
*/
module adc_core_model
  import adc_seq_pkg::*;
#(
  parameter int LATENCY = 8
)(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Sequencer side
  input  wire logic              core_start,
  input  wire logic [CHAN_W-1:0] core_channel,
  output logic                   core_done,
  output logic      [CODE_W-1:0] core_code,
  // Bench side
  input  wire logic [5:0]        code_bias,
  output logic      [15:0]       start_count
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_done <= 1'b0;
      core_code <= '0;
      start_count <= '0;
      wait_cnt <= 0;
    end else if (core_start) begin
      // Old code is void once a new conversion starts, so it is scrambled
      core_done <= 1'b0;
      core_code <= ~core_code;
      start_count <= start_count + 16'h0001;
      wait_cnt <= LATENCY;
    end else if (wait_cnt == 1) begin
      core_done <= 1'b1;
      core_code <= {core_channel, code_bias};
      wait_cnt <= 0;
    end else if (wait_cnt > 1) begin
      core_code <= ~core_code;
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : adc_core_model

// [verif/adc_conversion_sequencer_tb_top.sv]
/*
  Self-checking bench for the conversion sequencer: APB host tasks and scenarios.
  Assumes the core model on the analog side and a 20 MHz pclk.
*/
module adc_conversion_sequencer_tb_top
  import adc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic              core_power_en, core_cal, core_start, core_done, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [CHAN_W-1:0] core_channel;
  logic [CODE_W-1:0] core_code;
  logic [5:0]        code_bias;
  logic [15:0]       start_count;
  int                miscompares, check_count;

  adc_conversion_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_power_en(core_power_en), .core_cal(core_cal), .core_start(core_start),
    .core_channel(core_channel), .core_done(core_done), .core_code(core_code), .irq(irq));
  adc_core_model core (.pclk(pclk), .presetn(presetn), .core_start(core_start), .core_channel(core_channel),
    .core_done(core_done), .core_code(core_code), .code_bias(code_bias), .start_count(start_count));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  // Zero wait states are not assumed: the access phase lasts until pready
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask : rd

  function automatic logic [31:0] cw(input logic en, st, cont, hold, input logic [2:0] stop,
                                     input logic [3:0] first, inter, post);
    return {12'h000, post, inter, first, 1'b0, stop, hold, cont, st, en};
  endfunction : cw

  function automatic logic [CODE_W-1:0] ecode(input logic [CHAN_W-1:0] ch, input logic [5:0] b);
    return {ch, b} ^ ((ch == BATT_CURRENT_CH) ? 10'h200 : 10'h000);
  endfunction : ecode

  task automatic wait_start(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (core_start !== 1'b1);
  endtask : wait_start

  task automatic wait_done;
    logic [31:0] s;
    s = '0;
    while (s[STAT_DONE_BIT] !== 1'b1) rd(STATUS_OFS, s);
  endtask : wait_done

  task automatic check_res(input logic [31:0] sel, input int stop, input logic [5:0] b);
    logic [31:0] r, e;
    for (int k = 0; 2 * k <= stop; k++) begin
      rd(RESULT0_OFS + ADDR_W'(4 * k), r);
      e = {6'h00, ecode(sel[8*k+4 +: 4], b), 6'h00, ecode(sel[8*k +: 4], b)};
      if (2 * k + 1 > stop) begin
        r[31:16] = 16'h0;
        e[31:16] = 16'h0;
      end
      chk(r === e, "result word");
    end
  endtask : check_res

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    chk(core_cal === 1'b1 && core_power_en === 1'b1, "no power-up calibration");
    rd(CTRL_OFS, r);
    chk(r === 32'h0, "control reset value");
    rd(MASK_OFS, r);
    chk(r === 32'h0, "mask reset value");
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk(e === 1'b1 && r === 32'h0, "unmapped read accepted");
    r = 32'h4;
    while (r[STAT_CAL_BIT] !== 1'b0) rd(STATUS_OFS, r);
    chk(core_cal === 1'b0 && core_power_en === 1'b0, "core left powered");
    $display("test reset done");
  endtask : t_reset

  task automatic t_disabled;
    logic [31:0] r;
    logic [15:0] n0;
    n0 = start_count;
    wr(CTRL_OFS, cw(1'b0, 1'b1, 1'b0, 1'b0, 3'h7, 4'h0, 4'h0, 4'h0));
    repeat (1000) @(posedge pclk);
    rd(STATUS_OFS, r);
    chk(start_count === n0 && r[STAT_BUSY_BIT] === 1'b0, "converted while disabled");
    $display("test disabled done");
  endtask : t_disabled

  // Slot 0 reads battery voltage before slot 1 reads battery current
  task automatic t_single;
    logic [31:0] r;
    logic [15:0] n0;
    int          n;
    code_bias <= 6'h2a;
    wr(CHSEL_OFS, 32'h76543210);
    n0 = start_count;
    wr(CTRL_OFS, cw(1'b1, 1'b1, 1'b0, 1'b0, 3'h2, 4'h1, 4'h1, 4'h0));
    wait_start(n);
    chk(n >= 800 && n <= 1480, "first conversion timing");
    wr(CHSEL_OFS, 32'hfedcba98);
    wait_start(n);
    chk(n + 3 >= 800, "inter-conversion gap short");
    wait_done();
    chk(start_count - n0 === 16'h3, "conversion count");
    check_res(32'h76543210, 2, 6'h2a);
    rd(CTRL_OFS, r);
    chk(r[CTRL_START_BIT] === 1'b0, "start bit stuck");
    chk(irq === 1'b1, "no interrupt");
    wr(MASK_OFS, 32'h1);
    chk(irq === 1'b0, "masked interrupt seen");
    wr(MASK_OFS, 32'h0);
    wr(STATUS_OFS, 32'h1);
    rd(STATUS_OFS, r);
    chk(r[STAT_DONE_BIT] === 1'b0 && irq === 1'b0, "done flag not cleared");
    $display("test single done");
  endtask : t_single

  task automatic t_full;
    logic [15:0] n0;
    int          n;
    code_bias <= 6'h15;
    n0 = start_count;
    wr(CTRL_OFS, cw(1'b1, 1'b1, 1'b0, 1'b0, 3'h7, 4'h0, 4'h0, 4'hf));
    wait_start(n);
    // Sync bound plus one internal tick of granularity and a few register stages
    chk(n <= SYNC_NS / PCLK_PERIOD_NS + TICK_DIV + 5, "zero delay start late");
    wait_done();
    chk(start_count - n0 === 16'h8, "eight conversions");
    check_res(32'hfedcba98, 7, 6'h15);
    wr(STATUS_OFS, 32'h1);
    $display("test full done");
  endtask : t_full

  task automatic t_cont;
    logic [31:0] r;
    logic [15:0] n0;
    int          n, g1, g2;
    code_bias <= 6'h01;
    wr(CTRL_OFS, cw(1'b1, 1'b1, 1'b1, 1'b0, 3'h1, 4'h0, 4'h0, 4'h1));
    wait_start(n);
    wait_start(g1);
    wait_start(g2);
    chk(g1 < 800 && g2 >= 800, "post delay or loop wrong");
    wait_done();
    check_res(32'hfedcba98, 1, 6'h01);
    wr(CTRL_OFS, cw(1'b1, 1'b0, 1'b1, 1'b1, 3'h1, 4'h0, 4'h0, 4'h1));
    code_bias <= 6'h3c;
    repeat (4) wait_start(n);
    check_res(32'hfedcba98, 1, 6'h01);
    wr(CTRL_OFS, cw(1'b1, 1'b0, 1'b1, 1'b0, 3'h1, 4'h0, 4'h0, 4'h1));
    repeat (4) wait_start(n);
    check_res(32'hfedcba98, 1, 6'h3c);
    wr(CTRL_OFS, 32'h0);
    n0 = start_count;
    repeat (500) @(posedge pclk);
    rd(STATUS_OFS, r);
    chk(start_count === n0 && r[STAT_BUSY_BIT] === 1'b0 && core_power_en === 1'b0, "no stop");
    $display("test continuous done");
  endtask : t_cont

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    code_bias = '0;
    miscompares = 0;
    check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_disabled();
    t_single();
    t_full();
    t_cont();
    final_report();
  end

  // Whole run needs about 12500 cycles
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end
endmodule : adc_conversion_sequencer_tb_top
